// >>> hw/sadc_consts.svh
// constants of the serial command decoder and configuration register
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
`define SADC_CMD_PWDN     4'h8
`define SADC_CMD_RD_CFG   4'h9
`define SADC_CMD_WR_CFG   4'hA
`define SADC_CMD_TST_MID  4'hB
`define SADC_CMD_TST_LOW  4'hC
`define SADC_CMD_TST_HIGH 4'hD
`define SADC_CMD_FIFO_RD  4'hE
`define SADC_TEST_NONE    2'h0
`define SADC_TEST_MID     2'h1
`define SADC_TEST_LOW     2'h2
`define SADC_TEST_HIGH    2'h3
`define SADC_CFG_RESET    12'h000
`define SADC_CFG_REF_SRC  11
`define SADC_CFG_REF_LVL  10
`define SADC_CFG_LONG     9
`define SADC_CFG_CLK_HI   8
`define SADC_CFG_CLK_LO   7
`define SADC_CFG_MODE_HI  6
`define SADC_CFG_MODE_LO  5
`define SADC_CFG_ORD_HI   4
`define SADC_CFG_ORD_LO   3
`define SADC_CFG_PIN_EOC  2
`define SADC_CFG_THR_HI   1
`define SADC_CFG_THR_LO   0
`define SADC_CLK_OSC      2'h0
`define SADC_CLK_SCLK     2'h1
`define SADC_CLK_DIV4     2'h2
`define SADC_CLK_DIV2     2'h3
`define SADC_MODE_SINGLE  2'h0
`define SADC_SAMP_SHORT   5'h0C
`define SADC_SAMP_LONG    5'h18
`define SADC_THR_FULL     4'h8
`define SADC_THR_3Q       4'h6
`define SADC_THR_HALF     4'h4
`define SADC_THR_1Q       4'h2
`define SADC_LAST_BIT     4'hF
`define SADC_CMD_BIT      4'h3
`endif

// >>> hw/sadc_pkg.sv
// types of the serial command decoder
package sadc_pkg;
  typedef enum logic [1:0] {st_idle, st_shift, st_done} sadc_state_e;
  typedef struct packed {
    sadc_state_e st;
    logic        spi;
    logic [3:0]  in_cnt;
    logic [3:0]  out_cnt;
    logic [15:0] in_sr;
    logic [15:0] out_word;
    logic        sout;
    logic        oe;
    logic [11:0] cfg;
    logic        cfg_init;
    logic [3:0]  cmd;
    logic        pd;
    logic        samp_act;
    logic [4:0]  samp_cnt;
    logic [1:0]  div_cnt;
    logic [2:0]  sweep_idx;
    logic [2:0]  chan;
    logic [1:0]  test;
    logic        start_p;
    logic        end_p;
    logic        sw_pd_p;
    logic        pop_p;
    logic        tick;
    logic        busy_q;
    logic        int_f;
    logic        status_n;
  } sadc_regs_s;
endpackage

// >>> hw/sadc_edge_det.sv
// edge detector for the serial pins
`timescale 1ns/10ps
module sadc_edge_det (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [2:0] pins,
  output logic      [2:0] rise,
  output logic      [2:0] fall
);
  logic [2:0] prev_q;
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_pin
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          // start at the pin level so leaving reset shows no false edge
          prev_q[i] <= pins[i];
        end else begin
          prev_q[i] <= pins[i];
        end
      end
      assign rise[i] = pins[i] & ~prev_q[i];
      assign fall[i] = ~pins[i] & prev_q[i];
    end
  endgenerate
endmodule // sadc_edge_det

// >>> hw/sadc_sweep_seq.sv
// sweep channel sequence table
`timescale 1ns/10ps
module sadc_sweep_seq (
  input  wire logic [2:0] idx,
  input  wire logic [1:0] order,
  input  wire logic       eight_ch,
  output logic      [2:0] chan
);
  logic [2:0] c;
  always_comb begin
    case (order)
      2'h0:    c = idx;
      2'h1:    c = {idx[1:0], 1'b0};
      2'h2:    c = {idx[2:1], 1'b0};
      default: c = {1'b0, idx[0], 1'b0};
    endcase
    // four-channel part: even codes halve, order 00 runs as 01
    if (eight_ch) begin
      chan = c;
    end else if (order == 2'h0) begin
      chan = {1'b0, idx[1:0]};
    end else begin
      chan = {1'b0, c[2:1]};
    end
  end
endmodule // sadc_sweep_seq

// >>> hw/sadc_cmd_cfg.sv
// serial command decoder and 12-bit configuration register
//
// Behaviour
// (RQ1) frames are 16 bits msb first: 4-bit command then 12 data bits
// (RQ2) config read returns don't-care nibble then the 12 configuration bits
// (RQ3) conversion and fifo read return result in bits 15:4, zeros below
// (RQ4) results pass through as unipolar straight binary codes
// (RQ5) frame sync high at chip-select fall: capture rising, shift falling
// (RQ6) frame sync falling starts frame: capture falling, shift rising
// (RQ7) codes 0-7 select channels; four-channel part takes even codes only
// (RQ8) code 8 powers down analog and reference in software
// (RQ9) code A writes the following 12 data bits into configuration
// (RQ10) codes B, C, D select mid, low and high reference test inputs
// (RQ11) host must send A000h after power-up to set host interface
// (RQ12) configuration survives hardware and software power down
// (RQ13) a write may pause after 8 bits and resume with the clock
// (RQ14) configuration read is valid only in single-shot mode
// (RQ15) bit 11 picks reference source, bit 10 picks internal level
// (RQ16) bit 9 picks 12 or 24 serial clocks of sampling
// (RQ17) bits 8:7 pick conversion clock: osc, sclk, sclk/4, sclk/2
// (RQ18) bits 6:5 pick single, repeat, sweep or repeat sweep mode
// (RQ19) bits 4:3 pick sweep order, only used in sweep modes
// (RQ20) bit 2 makes status pin interrupt or end of conversion
// (RQ21) bits 1:0 pick fifo threshold full, 3/4, 1/2, 1/4
// (RQ22) quarter threshold fires after two entries are filled
// (RQ23) frame start clears 4-bit counter; output floats after 16 bits
// (RQ24) sampling starts after 4 bits only for conversion commands
`timescale 1ns/10ps
`include "sadc_consts.svh"
module sadc_cmd_cfg #(
  parameter bit EIGHT_CH = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        cs_n,
  input  wire logic        frame_sync,
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_oe,
  input  wire logic [11:0] result_data,
  input  wire logic        osc_tick,
  input  wire logic        conv_busy,
  input  wire logic [3:0]  fifo_count,
  input  wire logic        sweep_step,
  output logic             sample_start,
  output logic             sample_end,
  output logic      [2:0]  chan_sel,
  output logic      [1:0]  test_sel,
  output logic             sw_power_down,
  output logic             power_down,
  output logic             fifo_pop,
  output logic             conv_tick,
  output logic      [11:0] cfg_out,
  output logic             cfg_written,
  output logic             status_n,
  output logic      [2:0]  sweep_chan
);
  localparam sadc_pkg::sadc_regs_s RST = '{
    st: sadc_pkg::st_idle, cfg: `SADC_CFG_RESET, status_n: 1'b1,
    default: '0};

  sadc_pkg::sadc_regs_s q;
  sadc_pkg::sadc_regs_s d;
  logic [2:0]  rise;
  logic [2:0]  fall;
  logic        start_spi;
  logic        start_fs;
  logic        frame_go;
  logic        active;
  logic        cap;
  logic        shf;
  logic        dec;
  logic        fin;
  logic [3:0]  cmd_now;
  logic [15:0] word_now;
  logic        wr_fire;
  logic        is_chan;
  logic        is_test;
  logic        chan_ok;
  logic [2:0]  chan_now;
  logic [4:0]  samp_len;
  logic [3:0]  thr;
  logic        fifo_hit;
  logic        single;
  logic [2:0]  seq_chan;

  sadc_edge_det u_edge (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pins     ({serial_clk, frame_sync, cs_n}),
    .rise     (rise),
    .fall     (fall)
  );

  sadc_sweep_seq u_seq (
    .idx      (q.sweep_idx),
    .order    (q.cfg[`SADC_CFG_ORD_HI:`SADC_CFG_ORD_LO]),
    .eight_ch (EIGHT_CH),
    .chan     (seq_chan)
  );

  assign start_spi = fall[0] & frame_sync;                  // [RQ5]
  assign start_fs  = fall[1] & ~cs_n & ~start_spi;          // [RQ6]
  assign frame_go  = start_spi | start_fs;
  assign active    = (q.st == sadc_pkg::st_shift) & ~cs_n & ~frame_go;
  assign cap       = active & (q.spi ? rise[2] : fall[2]);  // [RQ5] [RQ6]
  assign shf       = (q.st != sadc_pkg::st_idle) & ~cs_n & ~frame_go
                     & (q.spi ? fall[2] : rise[2]);         // [RQ5] [RQ6]
  assign word_now  = {q.in_sr[14:0], serial_in};            // [RQ1]
  assign cmd_now   = word_now[3:0];
  assign dec       = cap & (q.in_cnt == `SADC_CMD_BIT);     // [RQ1]
  assign fin       = cap & (q.in_cnt == `SADC_LAST_BIT);
  assign wr_fire   = fin & (q.cmd == `SADC_CMD_WR_CFG);     // [RQ9]
  assign single    = q.cfg[`SADC_CFG_MODE_HI:`SADC_CFG_MODE_LO]
                     == `SADC_MODE_SINGLE;
  assign is_chan   = ~cmd_now[3];
  assign chan_ok   = EIGHT_CH | ~cmd_now[0];                // [RQ7]
  assign chan_now  = EIGHT_CH ? cmd_now[2:0]
                              : {1'b0, cmd_now[2:1]};       // [RQ7]
  assign is_test   = (cmd_now == `SADC_CMD_TST_MID) |
                     (cmd_now == `SADC_CMD_TST_LOW) |
                     (cmd_now == `SADC_CMD_TST_HIGH);
  assign samp_len  = q.cfg[`SADC_CFG_LONG] ? `SADC_SAMP_LONG
                                           : `SADC_SAMP_SHORT; // [RQ16]

  always_comb begin
    case (q.cfg[`SADC_CFG_THR_HI:`SADC_CFG_THR_LO])  // [RQ21]
      2'h0:    thr = `SADC_THR_FULL;
      2'h1:    thr = `SADC_THR_3Q;
      2'h2:    thr = `SADC_THR_HALF;
      default: thr = `SADC_THR_1Q;                   // [RQ22]
    endcase
  end
  assign fifo_hit = ~single & (fifo_count >= thr);   // [RQ21]

  always_comb begin
    d         = q;
    d.start_p = 1'b0;
    d.end_p   = 1'b0;
    d.sw_pd_p = 1'b0;
    d.pop_p   = 1'b0;
    d.tick    = 1'b0;
    d.busy_q  = conv_busy;
    if (frame_go) begin
      // counter cleared, previous result presented msb first
      d.st       = sadc_pkg::st_shift;                      // [RQ23]
      d.spi      = start_spi;
      d.in_cnt   = 4'h0;                                    // [RQ23]
      d.out_cnt  = 4'h0;
      d.in_sr    = 16'h0000;
      d.out_word = {result_data, 4'h0};                     // [RQ3] [RQ4]
      d.sout     = result_data[11];
      d.oe       = 1'b1;
      d.pd       = 1'b0;
      d.int_f    = 1'b0;
    end else if (cs_n) begin
      d.st = sadc_pkg::st_idle;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        sadc_pkg::st_shift: begin
          // edges only advance the frame, so a paused clock is harmless
          if (cap) begin                                    // [RQ13]
            d.in_sr  = word_now;
            d.in_cnt = q.in_cnt + 4'h1;
          end
          if (dec) begin
            d.cmd = cmd_now;
            if (cmd_now == `SADC_CMD_RD_CFG && single) begin
              d.out_word[11:0] = q.cfg;                     // [RQ2] [RQ14]
            end
            if (cmd_now == `SADC_CMD_PWDN) begin
              d.sw_pd_p = 1'b1;                             // [RQ8]
              d.pd      = 1'b1;                             // [RQ8] [RQ12]
            end
            if ((is_chan && chan_ok) || is_test) begin
              d.start_p  = 1'b1;                            // [RQ24]
              d.samp_act = 1'b1;
              d.samp_cnt = 5'h00;
              d.chan     = is_chan ? chan_now : q.chan;     // [RQ7]
              case (cmd_now)                                // [RQ10]
                `SADC_CMD_TST_MID:  d.test = `SADC_TEST_MID;
                `SADC_CMD_TST_LOW:  d.test = `SADC_TEST_LOW;
                `SADC_CMD_TST_HIGH: d.test = `SADC_TEST_HIGH;
                default:            d.test = `SADC_TEST_NONE;
              endcase
            end
          end
          if (fin) begin
            d.st = sadc_pkg::st_done;
            if (wr_fire) begin
              d.cfg       = word_now[11:0];                 // [RQ9] [RQ11]
              d.cfg_init  = 1'b1;
              d.sweep_idx = 3'h0;
            end
            if (q.cmd == `SADC_CMD_FIFO_RD) begin
              d.pop_p = 1'b1;                               // [RQ3]
            end
          end
          if (shf && q.oe) begin
            d.out_cnt = q.out_cnt + 4'h1;
            d.sout    = d.out_word[4'hF - d.out_cnt];
            if (q.out_cnt == `SADC_LAST_BIT) begin
              d.oe = 1'b0;                                  // [RQ23]
            end
          end
        end
        sadc_pkg::st_done: begin
          if (shf && q.oe) begin
            d.oe = 1'b0;                                    // [RQ23]
          end
        end
        default: begin
          d.oe = 1'b0;
        end
      endcase
    end
    // sampling window counted in serial clocks of the active polarity
    if (q.samp_act && !d.start_p && (q.spi ? rise[2] : fall[2])) begin
      d.samp_cnt = q.samp_cnt + 5'h01;
      if (d.samp_cnt == samp_len) begin                     // [RQ16]
        d.samp_act = 1'b0;
        d.end_p    = 1'b1;
      end
    end
    // conversion clock source
    if (rise[2]) begin
      d.div_cnt = q.div_cnt + 2'h1;
    end
    case (q.cfg[`SADC_CFG_CLK_HI:`SADC_CFG_CLK_LO])         // [RQ17]
      `SADC_CLK_OSC:  d.tick = osc_tick;
      `SADC_CLK_SCLK: d.tick = rise[2];
      `SADC_CLK_DIV4: d.tick = rise[2] & (q.div_cnt == 2'h3);
      default:        d.tick = rise[2] & q.div_cnt[0];
    endcase
    if (sweep_step && q.cfg[`SADC_CFG_MODE_HI]) begin       // [RQ19]
      d.sweep_idx = q.sweep_idx + 3'h1;
    end
    // interrupt: set wins over the frame-start clear
    if ((single && q.busy_q && !conv_busy) || fifo_hit) begin
      d.int_f = 1'b1;                                       // [RQ21]
    end
    d.status_n = q.cfg[`SADC_CFG_PIN_EOC] ? ~conv_busy
                                          : ~d.int_f;       // [RQ20]
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // reference and mode fields are carried out whole on cfg_out
  assign serial_out    = q.sout;
  assign serial_out_oe = q.oe;
  assign sample_start  = q.start_p;
  assign sample_end    = q.end_p;
  assign chan_sel      = q.chan;
  assign test_sel      = q.test;
  assign sw_power_down = q.sw_pd_p;
  assign power_down    = q.pd;
  assign fifo_pop      = q.pop_p;
  assign conv_tick     = q.tick;
  assign cfg_out       = q.cfg;                             // [RQ15] [RQ18]
  assign cfg_written   = q.cfg_init;
  assign status_n      = q.status_n;
  assign sweep_chan    = seq_chan;                          // [RQ19]

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic [11:0] wr_word;
  assign wr_word = word_now[11:0];

  a_spi_start: assert property (                                  // [RQ5]
    start_spi |=> serial_out_oe && q.spi && q.in_cnt == 4'h0)
    else $error("spi frame start not taken");
  a_fs_start: assert property (                                   // [RQ6]
    start_fs |=> serial_out_oe && !q.spi && q.in_cnt == 4'h0)
    else $error("frame sync start not taken");
  a_oe_after16: assert property (                                 // [RQ23]
    shf && q.oe && q.out_cnt == 4'hF |=> !serial_out_oe)
    else $error("output still driven after sixteenth bit");
  a_cs_float: assert property (                                   // [RQ23]
    cs_n ##1 cs_n |-> !serial_out_oe)
    else $error("output driven while chip select high");
  a_cfg_write: assert property (                                  // [RQ9]
    wr_fire |=> cfg_out == $past(wr_word) && cfg_written)
    else $error("configuration write lost");
  a_cfg_hold: assert property (                                   // [RQ12]
    !wr_fire |=> $stable(cfg_out))
    else $error("configuration changed without a write");
  a_conv_start: assert property (                                 // [RQ24]
    sample_start |-> $past(dec) && $past(cmd_now) != `SADC_CMD_PWDN)
    else $error("sampling started by a non-conversion command");
  a_pd_cmd: assert property (                                     // [RQ8]
    dec && cmd_now == `SADC_CMD_PWDN |=> sw_power_down ##1 power_down)
    else $error("software power down missed");
  a_rd_cfg: assert property (                                     // [RQ2]
    dec && cmd_now == `SADC_CMD_RD_CFG && single
      |=> q.out_word[11:0] == cfg_out)
    else $error("configuration not loaded for read");
  a_tail_zero: assert property (                                  // [RQ3]
    frame_go |=> q.out_word[3:0] == 4'h0)
    else $error("result tail not zero");
  a_odd_chan: assert property (                                   // [RQ7]
    dec && is_chan && !EIGHT_CH && cmd_now[0] |=> !sample_start)
    else $error("odd channel code accepted on four-channel part");

  c_cfg_write: cover property (wr_fire);
  c_fifo_read: cover property (fin && q.cmd == `SADC_CMD_FIFO_RD);
  c_samp_done: cover property (sample_start ##[1:300] sample_end);
endmodule // sadc_cmd_cfg

// >>> verification/sadc_host_model.sv
// host serial port model driving frames onto the four-wire link
`timescale 1ns/10ps
module sadc_host_model (
  input  wire logic        core_clk,
  output logic             cs_n,
  output logic             frame_sync,
  output logic             serial_clk,
  output logic             serial_in,
  input  wire logic        serial_out,
  output logic             rx_valid,
  output logic      [15:0] rx_word
);
  localparam int HALF = 4;
  initial begin
    cs_n = 1'b1;
    frame_sync = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
    rx_valid = 1'b0;
    rx_word = 16'h0000;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one frame; clock idles low for chip-select frames, high for sync frames
  task automatic xfer(input bit fs, input logic [15:0] w, input int nb,
                      input int pause);
    logic [15:0] r;
    r = 16'h0000;
    if (fs) begin
      if (cs_n) begin
        frame_sync <= 1'b0;
        wait_clk(2);
        cs_n <= 1'b0;
        wait_clk(2);
      end
      frame_sync <= 1'b1;
      serial_clk <= 1'b1;
      wait_clk(3);
      frame_sync <= 1'b0;
    end else begin
      cs_n <= 1'b1;
      frame_sync <= 1'b1;
      serial_clk <= 1'b0;
      wait_clk(3);
      cs_n <= 1'b0;
    end
    wait_clk(3);
    for (int i = 0; i < nb; i++) begin
      serial_in <= (i < 16) ? w[15-i] : 1'b0;
      wait_clk(HALF);
      serial_clk <= ~serial_clk;
      if (i < 16) r[15-i] = serial_out;
      wait_clk(HALF);
      serial_clk <= ~serial_clk;
      if (i == 7) wait_clk(pause);
    end
    wait_clk(2);
    if (!fs) cs_n <= 1'b1;
    serial_in <= ~serial_in;
    rx_word <= r;
    rx_valid <= 1'b1;
    wait_clk(1);
    rx_valid <= 1'b0;
    wait_clk(2);
  endtask
endmodule // sadc_host_model

// >>> verification/serial_adc_command_config_tb_top.sv
// self-checking bench of the serial command decoder
`timescale 1ns/10ps
`include "sadc_consts.svh"
module serial_adc_command_config_tb_top;
  logic        core_clk, nrst, cs_n, frame_sync, serial_clk, serial_in;
  logic        serial_out, serial_out_oe, osc_tick, conv_busy, sweep_step;
  logic        sample_start, sample_end, sw_power_down, power_down;
  logic        fifo_pop, conv_tick, cfg_written, status_n, rx_valid, sclk_d;
  logic [11:0] result_data, cfg_out, res, exp_cfg, d;
  logic [3:0]  fifo_count;
  logic [2:0]  chan_sel, sweep_chan;
  logic [1:0]  test_sel;
  logic [15:0] rx_word;
  logic [15:0] exp_q[$];
  logic [15:0] mask_q[$];
  int          failures, n_compared, seed, cycles, n_start, n_pop;
  int          samp_edges, exp_samp;
  int          n_tick, n_osc, n_start4, n_end, n_pd, t0, o0, nb_conv;
  logic        osc_d, start_four, sdo_line;
  logic [2:0]  chan_four, sweep_four;
  int          seq8[4][4] = '{'{0, 1, 2, 3}, '{0, 2, 4, 6}, '{0, 0, 2, 2},
                              '{0, 2, 0, 2}};
  int          seq4[4][4] = '{'{0, 1, 2, 3}, '{0, 1, 2, 3}, '{0, 0, 1, 1},
                              '{0, 1, 0, 1}};
  int          codes[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 11, 12, 13};
  int          thr[4] = '{8, 6, 4, 2};
  sadc_cmd_cfg uut (.core_clk(core_clk), .nrst(nrst), .cs_n(cs_n),
    .frame_sync(frame_sync), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .result_data(result_data),
    .osc_tick(osc_tick), .conv_busy(conv_busy), .fifo_count(fifo_count),
    .sweep_step(sweep_step), .sample_start(sample_start),
    .sample_end(sample_end), .chan_sel(chan_sel), .test_sel(test_sel),
    .sw_power_down(sw_power_down), .power_down(power_down),
    .fifo_pop(fifo_pop), .conv_tick(conv_tick), .cfg_out(cfg_out),
    .cfg_written(cfg_written), .status_n(status_n),
    .sweep_chan(sweep_chan));
  sadc_cmd_cfg #(.EIGHT_CH(1'b0)) uut_four (.core_clk(core_clk),
    .nrst(nrst), .cs_n(cs_n), .frame_sync(frame_sync),
    .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(),
    .serial_out_oe(), .result_data(result_data), .osc_tick(osc_tick),
    .conv_busy(conv_busy), .fifo_count(fifo_count),
    .sweep_step(sweep_step), .sample_start(start_four), .sample_end(),
    .chan_sel(chan_four), .test_sel(), .sw_power_down(), .power_down(),
    .fifo_pop(), .conv_tick(), .cfg_out(), .cfg_written(), .status_n(),
    .sweep_chan(sweep_four));
  // released line shows the inverse, so a bit taken while floating fails
  assign sdo_line = serial_out_oe ? serial_out : ~serial_out;
  sadc_host_model host (.core_clk(core_clk), .cs_n(cs_n),
    .frame_sync(frame_sync), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out(sdo_line),
    .rx_valid(rx_valid), .rx_word(rx_word));
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  task automatic complete_run;
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t port value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
                          input logic [15:0] m);
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      failures++;
      $display("ERROR %0t serial word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // conversion clock pulses expected over a frame of nb serial clocks
  function automatic int exp_ticks(input logic [1:0] src, input int nb,
                                   input int osc);
    case (src)
      2'h0:    return osc;
      2'h1:    return nb;
      2'h2:    return nb / 4;
      default: return nb / 2;
    endcase
  endfunction
  // kind 0 output ignored, 1 result word, 2 configuration word
  task automatic frame(input bit fs, input logic [15:0] w, input int nb,
                       input int pause, input int kind);
    res = 12'($random(seed));
    result_data <= res;
    exp_q.push_back(kind == 1 ? {res, 4'h0} : {4'h0, exp_cfg});
    mask_q.push_back(kind == 0 ? 16'h0000 :
                     (kind == 1 ? 16'hFFFF : 16'h0FFF));
    if (w[15:12] == `SADC_CMD_WR_CFG && nb >= 16) exp_cfg = w[11:0];
    host.xfer(fs, w, nb, pause);
    chk_out({15'h0000, serial_out_oe}, 16'h0000);
  endtask
  always @(posedge core_clk) begin
    if (rx_valid) chk_word(rx_word, exp_q.pop_front(),
                           mask_q.pop_front());
  end
  always @(posedge core_clk) begin
    sclk_d <= serial_clk;
    if (sample_start) begin
      n_start <= n_start + 1;
      samp_edges <= 0;
    end else if (serial_clk && !sclk_d) samp_edges <= samp_edges + 1;
    if (sample_end) chk_out(16'(samp_edges), 16'(exp_samp));
    if (fifo_pop) n_pop <= n_pop + 1;
    if (sample_end) n_end <= n_end + 1;
    if (start_four) n_start4 <= n_start4 + 1;
    if (sw_power_down) n_pd <= n_pd + 1;
    if (conv_tick) n_tick <= n_tick + 1;
    osc_d <= osc_tick;
    if (osc_d) n_osc <= n_osc + 1;
  end
  always @(posedge core_clk) begin
    cycles++;
    osc_tick <= (cycles % 3 == 0);
    if (cycles == 30000) begin
      failures++;
      $display("ERROR %0t run did not finish", $time);
      complete_run();
    end
  end
  initial begin
    nrst = 1'b0;
    result_data = 12'h000;
    conv_busy = 1'b0;
    fifo_count = 4'h0;
    sweep_step = 1'b0;
    sclk_d = 1'b0;
    seed = 23;
    exp_cfg = 12'h000;
    exp_samp = 12;
    wait_clk(8);
    nrst <= 1'b1;
    wait_clk(3);
    chk_out({4'h0, cfg_out}, {4'h0, `SADC_CFG_RESET});
    chk_out({15'h0000, status_n}, 16'h0001);
    frame(1'b0, 16'hA000, 16, 0, 0);
    chk_out({15'h0000, cfg_written}, 16'h0001);
    for (int lng = 0; lng < 2; lng++) begin
      d = 12'($random(seed));
      frame(1'b0, {4'hA, d[11:10], lng[0], d[8:7], 2'b00, d[4:0]}, 16, 0, 0);
      chk_out({4'h0, cfg_out}, {4'h0, exp_cfg});
      frame(1'b0, 16'h9000, 16, 0, 2);
      frame(1'b0, {4'hA, ~exp_cfg}, 8, 0, 0);
      chk_out({4'h0, cfg_out}, {4'h0, exp_cfg});
      exp_samp = lng ? 24 : 12;
      nb_conv = lng ? 28 : 16;
      for (int i = 0; i < 11; i++) begin
        t0 = n_tick;
        o0 = n_osc;
        frame(1'b0, {4'(codes[i]), 12'h000}, nb_conv, 0, 1);
        if (codes[i] < 8) chk_out({13'h0, chan_sel}, 16'(codes[i]));
        else chk_out({14'h0000, test_sel}, 16'(codes[i] - 10));
        if (codes[i] < 8 && codes[i] % 2 == 0)
          chk_out({13'h0, chan_four}, 16'(codes[i] / 2));
        chk_out(16'(n_tick - t0),
                16'(exp_ticks(exp_cfg[8:7], nb_conv, n_osc - o0)));
      end
    end
    frame(1'b0, 16'hE000, 16, 0, 1);
    chk_out(16'(n_pop), 16'h0001);
    frame(1'b0, 16'h8000, 16, 0, 0);
    chk_out({15'h0000, power_down}, 16'h0001);
    chk_out(16'(n_pd), 16'h0001);
    chk_out({4'h0, cfg_out}, {4'h0, exp_cfg});
    frame(1'b0, 16'hA004, 16, 0, 0);
    conv_busy <= 1'b1;
    wait_clk(4);
    chk_out({15'h0000, status_n}, 16'h0000);
    conv_busy <= 1'b0;
    wait_clk(4);
    chk_out({15'h0000, status_n}, 16'h0001);
    frame(1'b1, 16'hA000, 16, 20, 0);
    chk_out({4'h0, cfg_out}, 16'h0000);
    conv_busy <= 1'b1;
    wait_clk(4);
    chk_out({15'h0000, status_n}, 16'h0001);
    conv_busy <= 1'b0;
    wait_clk(4);
    chk_out({15'h0000, status_n}, 16'h0000);
    for (int t = 0; t < 4; t++) begin
      frame(1'b1, {4'hA, 7'h02, 2'(t), 1'b0, 2'(t)}, 16, 0, 0);
      fifo_count <= 4'(thr[t] - 1);
      wait_clk(4);
      chk_out({15'h0000, status_n}, 16'h0001);
      fifo_count <= 4'(thr[t]);
      wait_clk(4);
      chk_out({15'h0000, status_n}, 16'h0000);
      fifo_count <= 4'h0;
      for (int k = 0; k < 4; k++) begin
        chk_out({13'h0, sweep_chan}, 16'(seq8[t][k]));
        chk_out({13'h0, sweep_four}, 16'(seq4[t][k]));
        sweep_step <= 1'b1;
        wait_clk(1);
        sweep_step <= 1'b0;
        wait_clk(1);
      end
    end
    frame(1'b1, 16'h9000, 16, 0, 1);
    d = 12'($random(seed));
    frame(1'b1, {4'hA, d & 12'hF9F}, 16, 30, 0);
    frame(1'b1, 16'h9000, 16, 0, 2);
    chk_out(16'(n_start), 16'd22);
    chk_out(16'(n_start4), 16'h000E);
    chk_out(16'(n_end), 16'h0016);
    complete_run();
  end
endmodule // serial_adc_command_config_tb_top
